// [dv/tcc_timer16_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_sva
  import tcc_pkg::*;
#(
  parameter int unsigned NCMP = NUM_CMP
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_tick,
  input wire logic [NCMP-1:0][15:0] compare_values,
  input wire logic [NCMP-1:0] compare_match,
  input wire logic capture_event,
  input wire logic [15:0] running_count,
  input wire logic [15:0] captured_count
);
  logic blk_r;
  logic blk_nxt;
  logic wr_lo;
  assign wr_lo = psel && penable && pready && pwrite && pstrb[0]
    && paddr == 12'h290;
  // clears on any tick, so it only ever claims a block the design holds too
  always_comb
  begin
    blk_nxt = blk_r;
    if (wr_lo)
      blk_nxt = 1'h1;
    else if (timer_tick)
      blk_nxt = 1'h0;
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
      blk_r <= 1'h0;
    else
      blk_r <= blk_nxt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_RDY_WAIT: assert property ((psel && !penable) ##1 (psel && penable)
    |=> pready) else $error("ready late");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_ERR: assert property (pslverr |-> pready && paddr != 12'h290)
    else $error("bad error");
  AST_RST: assert property ($past(rst) |-> running_count == 16'h0000
    && captured_count == 16'h0000) else $error("reset value");
  AST_CNT_SRC: assert property ($changed(running_count) |->
    $past(timer_tick) || $past(pready && pwrite) || $past(rst))
    else $error("count moved");
  AST_MATCH: assert property (compare_match[0] |-> $past(timer_tick)
    && $past(running_count) == $past(compare_values[0]))
    else $error("false match");
  AST_BLOCK: assert property (blk_r && timer_tick && !wr_lo
    |=> compare_match == '0) else $error("match not blocked");
  AST_CAP: assert property (capture_event |->
    captured_count == $past(running_count)) else $error("capture value");
endmodule
bind tcc_timer16 tcc_timer16_sva #(.NCMP(NCMP)) u_tcc_timer16_sva (
  .core_clk(core_clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pstrb(pstrb),
  .pready(pready),
  .pslverr(pslverr),
  .timer_tick(timer_tick),
  .compare_values(compare_values),
  .compare_match(compare_match),
  .capture_event(capture_event),
  .running_count(running_count),
  .captured_count(captured_count)
);
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, v = 0;
  logic [3:0] pstrb = 4'h1;
  logic pready, pslverr, e, capture_event;
  logic timer_tick = 0, capture_input_pin = 0, comparator_out = 0;
  logic [1:0][15:0] compare_values = 0;
  logic [1:0] compare_match;
  logic [15:0] running_count, captured_count;
  int failures = 0, compares = 0, cyc = 0, caps = 0;
  logic [11:0] ra [4] = '{12'h290, 12'h298, 12'h290, 12'h298};
  logic [15:0] rv [4] = '{16'hA53C, 16'hFFFF, 16'h0001, 16'h8000};
  tcc_timer16 #(.NCMP(2)) u_tcc_timer16 (
    .core_clk(core_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .timer_tick(timer_tick),
    .capture_input_pin(capture_input_pin),
    .comparator_out(comparator_out),
    .compare_values(compare_values),
    .compare_match(compare_match),
    .capture_event(capture_event),
    .running_count(running_count),
    .captured_count(captured_count)
  );
  initial forever #4 core_clk = ~core_clk;
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // high byte first on writes, low byte first on reads
  task automatic w16(logic [11:0] a, logic [15:0] d);
    apb(1'h1, a + 12'h004, d[15:8]);
    apb(1'h1, a, d[7:0]);
  endtask
  task automatic r16(logic [11:0] a);
    apb(1'h0, a, 8'h00);
    v = 32'(q[7:0]);
    apb(1'h0, a + 12'h004, 8'h00);
    v[15:8] = q[7:0];
  endtask
  task automatic tk;
    timer_tick <= 1'h1;
    @(posedge core_clk);
    timer_tick <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic cp(logic p, logic c);
    capture_input_pin <= p;
    comparator_out <= c;
    repeat (3) @(posedge core_clk);
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (capture_event === 1'h1)
      caps++;
    if (cyc == 2000)
    begin
      failures++;
      close_out;
    end
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++)
    begin
      w16(ra[i], rv[i]);
      r16(ra[i]);
      chk("row", 32'(rv[i]), v);
    end
    rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    r16(12'h290);
    chk("cnt rst", 32'h0000_0000, v);
    r16(12'h298);
    chk("cap rst", 32'h0000_0000, v);
    apb(1'h0, 12'h004, 8'h00);
    chk("err", 32'h0000_0001, 32'(e));
    chk("unmapped", 32'h0000_0000, q);
    apb(1'h1, 12'h294, 8'h12);
    apb(1'h1, 12'h298, 8'h34);
    // the write lands on the completion edge; look one edge later
    @(posedge core_clk);
    chk("shared", 32'h0000_1234, 32'(captured_count));
    w16(12'h290, 16'h5678);
    apb(1'h1, 12'h29C, 8'hAA);
    apb(1'h0, 12'h290, 8'h00);
    apb(1'h0, 12'h29C, 8'h00);
    chk("latch", 32'h0000_0056, q);
    compare_values <= {16'h0003, 16'h0004};
    apb(1'h1, 12'h2C0, 8'h08);
    w16(12'h290, 16'h0003);
    tk;
    chk("blocked", 32'h0000_0000, 32'(compare_match));
    tk;
    chk("match", 32'h0000_0001, 32'(compare_match));
    tk;
    chk("count", 32'h0000_0006, 32'(running_count));
    pstrb <= 4'h0;
    apb(1'h1, 12'h290, 8'hEE);
    pstrb <= 4'h1;
    @(posedge core_clk);
    chk("strobe", 32'h0000_0006, 32'(running_count));
    apb(1'h1, 12'h2C0, 8'h01);
    cp(1'h1, 1'h0);
    chk("rise", 32'h0000_0006, 32'(captured_count));
    w16(12'h290, 16'h0888);
    apb(1'h1, 12'h2C0, 8'h00);
    cp(1'h0, 1'h0);
    chk("fall", 32'h0000_0888, 32'(captured_count));
    w16(12'h290, 16'h0999);
    apb(1'h1, 12'h2C0, 8'h03);
    cp(1'h1, 1'h0);
    chk("top", 32'h0000_0888, 32'(captured_count));
    apb(1'h1, 12'h2C0, 8'h05);
    // let the new source settle low before it rises
    cp(1'h1, 1'h0);
    cp(1'h1, 1'h1);
    chk("comp", 32'h0000_0999, 32'(captured_count));
    chk("events", 32'h0000_0003, 32'(caps));
    close_out;
  end
endmodule
`default_nettype wire

// [rtl/tcc_hold_latch.sv]
`timescale 1ns/1ps
`default_nettype none
// one high-byte holding latch shared by every 16-bit register
module tcc_hold_latch
  import tcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  tcc_if.store lat
);
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;

  always_comb
  begin
    hold_nxt = hold_r;
    if (lat.load)
      hold_nxt = lat.load_val;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      hold_r <= LATCH_RST;
    else
      hold_r <= hold_nxt;
  end

  assign lat.hold = hold_r;
endmodule
`default_nettype wire

// [rtl/tcc_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface tcc_if;
  logic load;
  logic [7:0] load_val;
  logic [7:0] hold;
  modport owner (output load, output load_val, input hold);
  modport store (input load, input load_val, output hold);
endinterface
`default_nettype wire

// [rtl/tcc_pkg.sv]
`default_nettype none
package tcc_pkg;
  localparam int unsigned ADDR_W = 12;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_COUNT_LO = 8'hA4;
  localparam logic [7:0] IDX_CAPT_LO = 8'hA6;
  localparam logic [7:0] IDX_HI_OFS = 8'h01;
  localparam logic [7:0] IDX_CTRL = 8'hB0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CAPT_RST = 16'h0000;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // control field positions
  localparam int unsigned CTRL_EDGE_BIT = 0;
  localparam int unsigned CTRL_TOP_BIT = 1;
  localparam int unsigned CTRL_SRC_BIT = 2;
  localparam int unsigned CTRL_RUN_BIT = 3;
  localparam int unsigned NUM_CMP = 2;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CNT_LO = 3'b001,
    SEL_CNT_HI = 3'b010,
    SEL_CAP_LO = 3'b011,
    SEL_CAP_HI = 3'b100,
    SEL_CTRL = 3'b101
  } tcc_sel_t;

  function automatic tcc_sel_t tcc_decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0)
      return SEL_NONE;
    else if (idx == IDX_COUNT_LO)
      return SEL_CNT_LO;
    else if (idx == IDX_COUNT_LO + IDX_HI_OFS)
      return SEL_CNT_HI;
    else if (idx == IDX_CAPT_LO)
      return SEL_CAP_LO;
    else if (idx == IDX_CAPT_LO + IDX_HI_OFS)
      return SEL_CAP_HI;
    else if (idx == IDX_CTRL)
      return SEL_CTRL;
    else
      return SEL_NONE;
  endfunction
endpackage
`default_nettype wire

// [rtl/tcc_timer16.sv]
// Summary of operation
// - running count is a low byte at index 0xA4 and high byte next.
// - software reads and overwrites the live count; it clears to zero on reset.
// - 16-bit count accesses pass through an 8-bit high-byte holding latch.
// - one holding latch serves every 16-bit register, not one per register.
// - a count write blocks compare matches on the next timer tick, all units.
// - matches only on equality at a tick; skipped-over values are lost.
// - captured count is read/write, low byte at index 0xA6, clears to zero.
// - a qualifying pin or comparator edge copies the count into the capture.
// - with the capture used as top, capture events are disabled.
// - edge select 0 captures on falling edges, 1 on rising edges.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16
  import tcc_pkg::*;
#(
  parameter int unsigned NCMP = NUM_CMP
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_tick,
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic [NCMP-1:0][15:0] compare_values,
  output logic [NCMP-1:0] compare_match,
  output logic capture_event,
  output logic [15:0] running_count,
  output logic [15:0] captured_count
);

  tcc_if lat_if ();

  tcc_hold_latch u_latch (
    .core_clk(core_clk),
    .rst(rst),
    .lat(lat_if.store)
  );

  // bus decode
  tcc_sel_t sel;
  logic acc_first;
  logic wr_done;
  logic rd_first;
  logic [7:0] wbyte;

  // the slave inserts one wait state so read data can leave a flip-flop
  assign sel = tcc_decode(paddr);
  assign acc_first = psel & penable & ~pready;
  assign wr_done = psel & penable & pready & pwrite & pstrb[0];
  assign rd_first = acc_first & ~pwrite;
  assign wbyte = pwdata[7:0];

  // bus answer state
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [7:0] rd_byte;

  // timer state
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] capt_r;
  logic [15:0] capt_nxt;
  logic [3:0] ctrl_r;
  logic [3:0] ctrl_nxt;
  logic block_r;
  logic block_nxt;
  logic [NCMP-1:0] match_r;
  logic [NCMP-1:0] match_nxt;
  logic cap_ev_r;
  logic cap_ev_nxt;
  logic src_prev_r;
  logic src_prev_nxt;
  logic src_ok_r;
  logic src_ok_nxt;

  logic tick_run;
  logic count_wr;
  logic capt_wr;
  logic src_now;
  logic edge_hit;
  logic cap_hit;

  assign tick_run = timer_tick & ctrl_r[CTRL_RUN_BIT];
  // a low-byte write commits the latched high byte with it
  assign count_wr = wr_done & (sel == SEL_CNT_LO);
  assign capt_wr = wr_done & (sel == SEL_CAP_LO);
  assign src_now = ctrl_r[CTRL_SRC_BIT] ? comparator_out : capture_input_pin;

  always_comb
  begin
    if (ctrl_r[CTRL_EDGE_BIT])
      edge_hit = src_now & ~src_prev_r;
    else
      edge_hit = ~src_now & src_prev_r;
  end

  // the source is not judged until one sample exists after reset
  assign cap_hit = edge_hit & src_ok_r & ~ctrl_r[CTRL_TOP_BIT];

  // read path and latch loading
  always_comb
  begin
    rd_byte = 8'h00;
    lat_if.load = 1'b0;
    lat_if.load_val = 8'h00;
    case (sel)
      SEL_CNT_LO:
      begin
        rd_byte = count_r[7:0];
        // high byte frozen now so a later high read pairs with this low
        lat_if.load = rd_first;
        lat_if.load_val = count_r[15:8];
      end
      SEL_CNT_HI:
      begin
        rd_byte = lat_if.hold;
        lat_if.load = wr_done;
        lat_if.load_val = wbyte;
      end
      SEL_CAP_LO:
      begin
        rd_byte = capt_r[7:0];
        lat_if.load = rd_first;
        lat_if.load_val = capt_r[15:8];
      end
      SEL_CAP_HI:
      begin
        rd_byte = lat_if.hold;
        lat_if.load = wr_done;
        lat_if.load_val = wbyte;
      end
      SEL_CTRL:
      begin
        rd_byte = {4'h0, ctrl_r};
      end
      default:
      begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always_comb
  begin
    pready_nxt = acc_first;
    pslverr_nxt = acc_first & (sel == SEL_NONE);
    prdata_nxt = prdata_r;
    if (rd_first)
      prdata_nxt = {24'h0000_00, rd_byte};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // counter, compare blocking and matches
  always_comb
  begin
    count_nxt = count_r;
    block_nxt = block_r;
    match_nxt = '0;
    ctrl_nxt = ctrl_r;
    if (wr_done && sel == SEL_CTRL)
      ctrl_nxt = wbyte[3:0];
    if (count_wr)
    begin
      // a write beats a tick in the same cycle; that tick is dropped
      count_nxt = {lat_if.hold, wbyte};
      block_nxt = 1'b1;
    end
    else if (tick_run)
    begin
      block_nxt = 1'b0;
      for (int i = 0; i < NCMP; i++)
      begin
        // strict equality at the tick: values jumped over never match
        match_nxt[i] = ~block_r & (count_r == compare_values[i]);
      end
      if (ctrl_r[CTRL_TOP_BIT] && count_r == capt_r)
        count_nxt = COUNT_RST;
      else
        count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      count_r <= COUNT_RST;
      block_r <= 1'b0;
      match_r <= '0;
      ctrl_r <= CTRL_RST;
    end
    else
    begin
      count_r <= count_nxt;
      block_r <= block_nxt;
      match_r <= match_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // capture unit
  always_comb
  begin
    capt_nxt = capt_r;
    cap_ev_nxt = cap_hit;
    src_prev_nxt = src_now;
    src_ok_nxt = 1'b1;
    // a hardware capture wins over a software write in the same cycle
    if (cap_hit)
      capt_nxt = count_r;
    else if (capt_wr)
      capt_nxt = {lat_if.hold, wbyte};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      capt_r <= CAPT_RST;
      cap_ev_r <= 1'b0;
      src_prev_r <= 1'b0;
      src_ok_r <= 1'b0;
    end
    else
    begin
      capt_r <= capt_nxt;
      cap_ev_r <= cap_ev_nxt;
      src_prev_r <= src_prev_nxt;
      src_ok_r <= src_ok_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign compare_match = match_r;
  assign capture_event = cap_ev_r;
  assign running_count = count_r;
  assign captured_count = capt_r;
endmodule
`default_nettype wire
